// File: core/dpv_pkg.sv
// Shared constants for the display pixel and video port
package dpv_pkg;
    localparam int CNT_W = 10;
    localparam int PIX_W = 18;
    localparam int VID_W = 8;
    localparam int VFIFO_DEPTH = 8;
    // Cycle counter for measuring dot clock half periods
    localparam int HALF_W = 6;
    // Own clock cycles per half period of the video port clock
    localparam logic [1:0] VID_HALF_CYC = 2'h2;
    // CRT line timing, in pixel clock periods
    localparam logic [CNT_W-1:0] CRT_H_ACTIVE = 10'h010;
    localparam logic [CNT_W-1:0] CRT_HS_START = 10'h012;
    localparam logic [CNT_W-1:0] CRT_HS_END = 10'h016;
    localparam logic [CNT_W-1:0] CRT_H_TOTAL = 10'h01a;
    // CRT frame timing, in lines
    localparam logic [CNT_W-1:0] CRT_V_ACTIVE = 10'h004;
    localparam logic [CNT_W-1:0] CRT_VS_START = 10'h005;
    localparam logic [CNT_W-1:0] CRT_VS_END = 10'h006;
    localparam logic [CNT_W-1:0] CRT_V_TOTAL = 10'h008;
    // Panel sync windows, same line and frame lengths as the CRT
    localparam logic [CNT_W-1:0] PNL_HS_START = 10'h011;
    localparam logic [CNT_W-1:0] PNL_HS_END = 10'h014;
    localparam logic [CNT_W-1:0] PNL_VS_START = 10'h004;
    localparam logic [CNT_W-1:0] PNL_VS_END = 10'h005;
endpackage : dpv_pkg

// File: core/dpv_port.sv
// Pixel bus, sync generation and video byte port toward the companion chip
// Behaviour
// - Pixel port clock runs at dot rate, or twice it in double mode.
// - Pixel port clock paces the transfer of graphics words.
// - Pixel bus changes only with the pixel port clock falling edge.
// - Video port clock toggles only while the video port is enabled.
// - Video bytes change only with the video port clock falling edge.
// - Video valid marks each byte the companion is to take.
// - CRT line sync marks line rate and horizontal retrace.
// - CRT frame sync marks refresh rate and vertical retrace.
// - Panel line sync has its own window, apart from CRT.
// - Panel frame sync has its own window, apart from CRT.
// - Every sync output has its own selectable polarity.
// - Display flag high in active pixels, low in blanking.
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
module dpv_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_r;
    logic [AW-1:0] rd_r;
    logic [AW:0] cnt_r;
    logic [AW:0] cnt_nxt;
    // Room flag is a flop held low through reset, so ready never shows before release
    logic room_r;
    wire push = in_valid && room_r;
    wire pop = out_ready && (cnt_r != '0);

    assign cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    assign in_ready = room_r;
    assign out_valid = (cnt_r != '0);
    assign out_data = mem[rd_r];

    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_r] <= in_data;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            wr_r <= '0;
            rd_r <= '0;
            cnt_r <= '0;
            room_r <= 1'b0;
        end else begin
            wr_r <= push ? AW'(wr_r + 1'b1) : wr_r;
            rd_r <= pop ? AW'(rd_r + 1'b1) : rd_r;
            cnt_r <= cnt_nxt;
            room_r <= (cnt_nxt != (AW+1)'(DEPTH));
        end
    end
endmodule : dpv_fifo

////////////////////////////////////////////////////////////////////////////////
module dpv_port (
    input wire logic clock,
    input wire logic rstn,
    input wire logic dot_clock_in,
    input wire logic double_rate_mode,
    input wire logic [17:0] pixel_data,
    output logic pixel_take,
    output logic pixel_port_clock,
    output logic [17:0] pixel_bus,
    input wire logic crt_line_pol,
    input wire logic crt_frame_pol,
    input wire logic panel_line_pol,
    input wire logic panel_frame_pol,
    output logic crt_line_sync,
    output logic crt_frame_sync,
    output logic panel_line_sync,
    output logic panel_frame_sync,
    output logic active_display_flag,
    input wire logic video_port_enable,
    input wire logic [7:0] video_in_data,
    input wire logic video_in_valid,
    output logic video_in_ready,
    input wire logic video_fifo_ready,
    output logic video_port_clock,
    output logic video_byte_valid,
    output logic [7:0] yuv_stream_bus
);
    localparam int CW = dpv_pkg::CNT_W;
    localparam int HW = dpv_pkg::HALF_W;

    // Sync output level: pol high means asserted high
    function automatic logic sync_lvl(input logic [CW-1:0] c, input logic [CW-1:0] s,
                                      input logic [CW-1:0] e, input logic pol);
        sync_lvl = ((c >= s) && (c < e)) ? pol : !pol;
    endfunction : sync_lvl

    ////////////////////////////////////////////////////////////////////////////
    // Dot clock and companion ready sampling
    logic dot_s1_r;
    logic dot_s2_r;
    logic dot_prev_r;
    logic rdy_s1_r;
    logic rdy_s2_r;

    always_ff @(posedge clock) begin
        if (!rstn) begin
            dot_s1_r <= 1'b0;
            dot_s2_r <= 1'b0;
            dot_prev_r <= 1'b0;
            rdy_s1_r <= 1'b0;
            rdy_s2_r <= 1'b0;
        end else begin
            dot_s1_r <= dot_clock_in;
            dot_s2_r <= dot_s1_r;
            dot_prev_r <= dot_s2_r;
            rdy_s1_r <= video_fifo_ready;
            rdy_s2_r <= rdy_s1_r;
        end
    end

    wire dot_edge = dot_s2_r ^ dot_prev_r;

    ////////////////////////////////////////////////////////////////////////////
    // Pixel port clock
    logic [HW-1:0] cyc_r;
    logic [HW-1:0] half_r;
    logic pclk_r;
    logic pclk_nxt;

    // Double mode adds a toggle mid-way through each measured half period
    wire mid = double_rate_mode && !dot_edge && (half_r > HW'(1))
               && (cyc_r == HW'((half_r >> 1) - HW'(1)));
    assign pclk_nxt = double_rate_mode ? (pclk_r ^ (dot_edge | mid)) : dot_s2_r;
    wire pix_tick = pclk_r && !pclk_nxt;

    always_ff @(posedge clock) begin
        if (!rstn) begin
            cyc_r <= '0;
            half_r <= '0;
            pclk_r <= 1'b0;
        end else begin
            cyc_r <= dot_edge ? '0 : ((&cyc_r) ? cyc_r : HW'(cyc_r + 1'b1));
            half_r <= dot_edge ? HW'(cyc_r + 1'b1) : half_r;
            pclk_r <= pclk_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Raster counters
    logic [CW-1:0] h_r;
    logic [CW-1:0] v_r;
    wire h_last = (h_r == dpv_pkg::CRT_H_TOTAL - 10'h001);
    wire v_last = (v_r == dpv_pkg::CRT_V_TOTAL - 10'h001);
    wire in_active = (h_r < dpv_pkg::CRT_H_ACTIVE) && (v_r < dpv_pkg::CRT_V_ACTIVE);

    always_ff @(posedge clock) begin
        if (!rstn) begin
            h_r <= '0;
            v_r <= '0;
        end else if (pix_tick) begin
            h_r <= h_last ? '0 : CW'(h_r + 1'b1);
            if (h_last) begin
                v_r <= v_last ? '0 : CW'(v_r + 1'b1);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pixel bus and syncs, all updated on the pixel clock falling edge
    logic [17:0] pix_r;
    logic take_r;
    logic de_r;
    logic chs_r;
    logic cvs_r;
    logic phs_r;
    logic pvs_r;

    always_ff @(posedge clock) begin
        if (!rstn) begin
            pix_r <= '0;
            take_r <= 1'b0;
            de_r <= 1'b0;
            chs_r <= 1'b0;
            cvs_r <= 1'b0;
            phs_r <= 1'b0;
            pvs_r <= 1'b0;
        end else begin
            take_r <= pix_tick && in_active;
            if (pix_tick) begin
                pix_r <= in_active ? pixel_data : '0;
                de_r <= in_active;
                chs_r <= sync_lvl(h_r, dpv_pkg::CRT_HS_START, dpv_pkg::CRT_HS_END, crt_line_pol);
                cvs_r <= sync_lvl(v_r, dpv_pkg::CRT_VS_START, dpv_pkg::CRT_VS_END,
                                  crt_frame_pol);
                phs_r <= sync_lvl(h_r, dpv_pkg::PNL_HS_START, dpv_pkg::PNL_HS_END,
                                  panel_line_pol);
                pvs_r <= sync_lvl(v_r, dpv_pkg::PNL_VS_START, dpv_pkg::PNL_VS_END,
                                  panel_frame_pol);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Video byte port
    logic [7:0] fifo_data;
    logic fifo_valid;
    logic [1:0] vdiv_r;
    logic vclk_r;
    logic vval_r;
    logic [7:0] vdat_r;

    wire vtick = (vdiv_r == dpv_pkg::VID_HALF_CYC - 2'h1);
    wire vfall = video_port_enable && vtick && vclk_r;
    // pop only while companion has room
    wire vpop = vfall && rdy_s2_r && fifo_valid;

    dpv_fifo #(
        .WIDTH(dpv_pkg::VID_W),
        .DEPTH(dpv_pkg::VFIFO_DEPTH)
    ) u_vfifo (
        .clock(clock),
        .rstn(rstn),
        .in_data(video_in_data),
        .in_valid(video_in_valid),
        .in_ready(video_in_ready),
        .out_data(fifo_data),
        .out_valid(fifo_valid),
        .out_ready(vpop)
    );

    always_ff @(posedge clock) begin
        if (!rstn || !video_port_enable) begin
            vdiv_r <= '0;
            vclk_r <= 1'b0;
            vval_r <= 1'b0;
        end else begin
            vdiv_r <= vtick ? '0 : 2'(vdiv_r + 1'b1);
            vclk_r <= vclk_r ^ vtick;
            if (vfall) begin
                vval_r <= vpop;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            vdat_r <= '0;
        end else if (vpop) begin
            vdat_r <= fifo_data;
        end
    end

    assign pixel_port_clock = pclk_r;
    assign pixel_bus = pix_r;
    assign pixel_take = take_r;
    assign active_display_flag = de_r;
    assign crt_line_sync = chs_r;
    assign crt_frame_sync = cvs_r;
    assign panel_line_sync = phs_r;
    assign panel_frame_sync = pvs_r;
    assign video_port_clock = vclk_r;
    assign video_byte_valid = vval_r;
    assign yuv_stream_bus = vdat_r;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    sequence s_vfall_not_ready;
        video_port_enable && vtick && vclk_r && !rdy_s2_r;
    endsequence
    sequence s_line_sync_start;
        pix_tick && (h_r == dpv_pkg::CRT_HS_START);
    endsequence

    AST_PCLK_FOLLOW: assert property (!double_rate_mode && $rose(dot_s2_r)
        |=> $rose(pclk_r)) else $error("pixel clock missed dot rise");
    AST_PCLK_DOUBLE: assert property (double_rate_mode && dot_edge
        |=> $changed(pclk_r)) else $error("pixel clock missed dot edge");
    AST_PIX_ON_FALL: assert property ($changed(pix_r) |-> $fell(pclk_r))
        else $error("pixel bus moved off falling edge");
    AST_TAKE_PACE: assert property (take_r |-> $fell(pclk_r) && de_r)
        else $error("pixel take not paced by pixel clock");
    AST_VCLK_IDLE: assert property (!video_port_enable |=> !vclk_r && !vval_r)
        else $error("video clock active while disabled");
    AST_VDATA_FALL: assert property ($changed(vdat_r) |-> $fell(vclk_r))
        else $error("video byte moved off falling edge");
    AST_VALID_RDY: assert property ($rose(vval_r) |-> $past(rdy_s2_r))
        else $error("valid raised without ready");
    AST_STOP_NOT_READY: assert property (s_vfall_not_ready |=> !vval_r && $stable(vdat_r))
        else $error("new byte presented while not ready");
    AST_CRT_LINE_POL: assert property (s_line_sync_start
        |=> chs_r == crt_line_pol) else $error("line sync polarity wrong");
    AST_BLANK_FLAG: assert property (pix_tick && (h_r >= dpv_pkg::CRT_H_ACTIVE)
        |=> !de_r) else $error("display flag high in blanking");
    AST_FRAME_POL: assert property (pix_tick && (v_r == dpv_pkg::CRT_VS_START)
        |=> cvs_r == crt_frame_pol && pvs_r == !panel_frame_pol)
        else $error("frame sync level wrong");
endmodule : dpv_port

// File: testbench/dpv_companion.sv
// Companion chip model: dot clock source and video FIFO receiver
`timescale 1ns/10ps
module dpv_companion #(
    parameter int CAP = 6
) (
    input wire logic clock,
    input wire logic stall,
    input wire logic video_port_clock,
    input wire logic video_byte_valid,
    input wire logic [7:0] yuv_stream_bus,
    input wire logic panel_line_sync,
    input wire logic panel_frame_sync,
    output logic [1:0] panel_redrive,
    output logic dot_clock_in,
    output logic video_fifo_ready
);
    logic [7:0] held[$];
    logic [7:0] got[$];
    int n_bad = 0;
    // panel syncs passed straight on to the panel
    assign panel_redrive = {panel_line_sync, panel_frame_sync};
    initial begin
        dot_clock_in = 1'b0;
        #7;
        forever #160 dot_clock_in = ~dot_clock_in;
    end
    // take byte on rise with valid
    always @(posedge video_port_clock) begin
        if (video_byte_valid === 1'b1) begin
            if (held.size() >= CAP) n_bad++;
            held.push_back(yuv_stream_bus);
        end
    end
    always @(posedge clock) begin
        if (!stall && held.size() > 0) got.push_back(held.pop_front());
    end
    // ready only with room
    // Two slots kept back for the device's synchroniser lag
    always @(negedge clock) video_fifo_ready <= (held.size() < CAP - 2);
endmodule : dpv_companion

// File: testbench/tb_display_pixel_video_port.sv
// Self-checking bench for the display pixel and video port
`timescale 1ns/10ps
module tb_display_pixel_video_port;
    typedef struct packed {logic [3:0] pol; logic dbl; logic [3:0] per;} dpv_row_t;
    localparam dpv_row_t ROWS [4] = '{'{4'h0, 1'b0, 4'h8}, '{4'hf, 1'b0, 4'h8},
        '{4'h5, 1'b1, 4'h4}, '{4'ha, 1'b1, 4'h4}};
    logic clock, rstn, dot_clock_in, double_rate_mode, pixel_take, pixel_port_clock;
    logic [17:0] pixel_data, pixel_bus;
    logic [3:0] pol, exp_s;
    logic crt_line_sync, crt_frame_sync, panel_line_sync, panel_frame_sync, active_display_flag;
    logic video_port_enable, video_in_valid, video_in_ready, video_fifo_ready, video_port_clock;
    logic video_byte_valid, stall, pclk_q, vclk_q, act;
    logic [7:0] video_in_data, yuv_stream_bus;
    logic [1:0] panel_redrive;
    logic [dpv_pkg::CNT_W-1:0] h, v;
    wire logic [3:0] syncs = {crt_line_sync, crt_frame_sync, panel_line_sync, panel_frame_sync};
    int n_errors = 0, tests_run = 0, cyc = 0, last_tick = 0, per_seen = 0, vlast = 0, vper = 0;
    int n_acc;

    dpv_port dut_u (.clock(clock), .rstn(rstn), .dot_clock_in(dot_clock_in),
        .double_rate_mode(double_rate_mode), .pixel_data(pixel_data), .pixel_take(pixel_take),
        .pixel_port_clock(pixel_port_clock), .pixel_bus(pixel_bus), .crt_line_pol(pol[3]),
        .crt_frame_pol(pol[2]), .panel_line_pol(pol[1]), .panel_frame_pol(pol[0]),
        .crt_line_sync(crt_line_sync), .crt_frame_sync(crt_frame_sync),
        .panel_line_sync(panel_line_sync), .panel_frame_sync(panel_frame_sync),
        .active_display_flag(active_display_flag), .video_port_enable(video_port_enable),
        .video_in_data(video_in_data), .video_in_valid(video_in_valid),
        .video_in_ready(video_in_ready), .video_fifo_ready(video_fifo_ready),
        .video_port_clock(video_port_clock), .video_byte_valid(video_byte_valid),
        .yuv_stream_bus(yuv_stream_bus));
    dpv_companion peer_u (.clock(clock), .stall(stall), .video_port_clock(video_port_clock),
        .video_byte_valid(video_byte_valid), .yuv_stream_bus(yuv_stream_bus),
        .panel_line_sync(panel_line_sync), .panel_frame_sync(panel_frame_sync),
        .panel_redrive(panel_redrive),
        .dot_clock_in(dot_clock_in), .video_fifo_ready(video_fifo_ready));

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic in_rng(input logic [9:0] x, input logic [9:0] lo, hi);
        return (x >= lo) && (x < hi);
    endfunction : in_rng

    task automatic check(input string what, input logic [17:0] exp, input logic [17:0] got);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic conclude();
        $display("checks %0d errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : conclude

    task automatic do_reset();
        rstn = 1'b0;
        repeat (20) @(negedge clock);
        check("reset_outputs", 18'h0, {9'h0, pixel_port_clock, syncs, active_display_flag,
            video_port_clock, video_byte_valid, video_in_ready});
        rstn = 1'b1;
        @(negedge clock);
        check("ready_after_reset", 18'h1, {17'h0, video_in_ready});
    endtask : do_reset

    // Held data is kept on refusal, so bytes stay in order
    task automatic push_bytes(input int n_max, output int n_ok);
        logic ok;
        n_ok = 0;
        video_in_valid = 1'b1;
        for (int i = 0; i < n_max; i++) begin
            video_in_data = 8'h40 + 8'(n_ok);
            // Ready is settled mid-cycle; the coming rise pushes only if it is high
            ok = video_in_ready;
            @(negedge clock);
            if (ok === 1'b1) n_ok++;
        end
        video_in_valid = 1'b0;
    endtask : push_bytes

    ////////////////////////////////////////////////////////////////////////////////
    // Raster model, advanced at each falling pixel port clock
    always @(negedge clock) begin
        if (!rstn) begin
            h = '0;
            v = '0;
            pclk_q = 1'b0;
            vclk_q = 1'b0;
        end else begin
            cyc++;
            act = (h < dpv_pkg::CRT_H_ACTIVE) && (v < dpv_pkg::CRT_V_ACTIVE);
            if (pclk_q && !pixel_port_clock) begin
                per_seen = cyc - last_tick;
                last_tick = cyc;
                exp_s = pol ~^ {in_rng(h, dpv_pkg::CRT_HS_START, dpv_pkg::CRT_HS_END),
                    in_rng(v, dpv_pkg::CRT_VS_START, dpv_pkg::CRT_VS_END),
                    in_rng(h, dpv_pkg::PNL_HS_START, dpv_pkg::PNL_HS_END),
                    in_rng(v, dpv_pkg::PNL_VS_START, dpv_pkg::PNL_VS_END)};
                check("syncs", {14'h0, exp_s}, {14'h0, syncs});
                check("panel_redrive", {16'h0, exp_s[1:0]}, {16'h0, panel_redrive});
                check("display_flag", {17'h0, act}, {17'h0, active_display_flag});
                check("pixel_take", {17'h0, act}, {17'h0, pixel_take});
                check("pixel_bus", act ? pixel_data : 18'h0, pixel_bus);
                h = (h == dpv_pkg::CRT_H_TOTAL - 1) ? '0 : h + 1'b1;
                if (h == '0) v = (v == dpv_pkg::CRT_V_TOTAL - 1) ? '0 : v + 1'b1;
            end else begin
                check("take_idle", 18'h0, {17'h0, pixel_take});
            end
            if (!video_port_enable) check("vclk_off", 18'h0, {17'h0, video_port_clock});
            if (!vclk_q && video_port_clock) begin
                vper = cyc - vlast;
                vlast = cyc;
            end
            pclk_q = pixel_port_clock;
            vclk_q = video_port_clock;
        end
        pixel_data = pixel_data + 18'h1;
    end

    initial begin
        repeat (20000) @(posedge clock);
        n_errors++;
        conclude();
    end

    initial begin
        rstn = 1'b0;
        double_rate_mode = 1'b0;
        pixel_data = 18'h0;
        pol = 4'h0;
        video_port_enable = 1'b0;
        video_in_valid = 1'b0;
        video_in_data = 8'h0;
        stall = 1'b1;
        @(negedge clock);
        for (int i = 0; i < 4; i++) begin
            // Reset first, then move the row settings, so no check mixes two rows
            rstn = 1'b0;
            @(negedge clock);
            pol = ROWS[i].pol;
            double_rate_mode = ROWS[i].dbl;
            do_reset();
            repeat (1700) @(negedge clock);
            check("pixel_period", {14'h0, ROWS[i].per}, per_seen[17:0]);
        end
        // Far side stalled: fill both FIFOs until refused
        video_port_enable = 1'b1;
        repeat (20) @(negedge clock);
        push_bytes(20, n_acc);
        check("push_refused", 18'h1, {17'h0, n_acc < 20});
        check("push_depth", 18'h1, {17'h0, n_acc >= dpv_pkg::VFIFO_DEPTH});
        repeat (100) @(negedge clock);
        check("valid_stalled", 18'h0, {17'h0, video_byte_valid});
        stall = 1'b0;
        for (int k = 0; k < 800 && peer_u.got.size() < n_acc; k++) @(negedge clock);
        check("got_count", 18'(n_acc), 18'(peer_u.got.size()));
        foreach (peer_u.got[k]) begin
            check("video_byte", 18'(8'h40 + 8'(k)), 18'(peer_u.got[k]));
        end
        check("overrun", 18'h0, 18'(peer_u.n_bad));
        check("video_period", 18'h4, 18'(vper));
        conclude();
    end
endmodule : tb_display_pixel_video_port
